// ### rtl/pgbtp_pkg.sv
// Constants, types and config carriers for the pixel gain, black level and pattern path
// Overview of operation
// RULE_01: Analog gain per colour equals (1 + doubler) times coarse gain over eight.
// RULE_02: Doubler bit holds only 0 or 1, giving a factor of 1 or 2.
// RULE_03: Software keeps coarse gain 1 to 4 and uses the doubler above 4.
// RULE_04: Digital gain per colour equals 1 plus fine gain over eight.
// RULE_05: Analog offset per colour comes from the loop or software, coarse steps.
// RULE_06: Row offset from averaged dark columns, or software offset when row loop is off.
// RULE_07: Even/odd column offset computed from dark rows, or set manually.
// RULE_08: Analog loop samples dark rows and steps offset only when outside targets.
// RULE_09: Green lock with equal green gains makes first green offset serve both.
// RULE_10: Red/blue lock with equal gains makes the red offset serve blue too.
// RULE_11: Offsets read back are those in use; manual writes apply on manual mode.
// RULE_12: Manual black level mode stops all sampling and adjusting; the code stops only the analog loop.
// RULE_13: Final black correction is last, undoes gain shift, active columns of all rows.
// RULE_14: Enabled test pattern, chosen by mode 0 to 8, replaces samples at pipe head.
// RULE_15: Dark pixels get colour pattern values; active pixels get the selected pattern.
// RULE_16: Software turns black level calibration off while a test pattern runs.
// RULE_17: Classic pattern feeds test data, alternating between even and odd columns.
// RULE_18: Colour field gives each pixel the green, red or blue value by colour.
// RULE_19: Gradients count active pixels, active rows, or combine both counters.
// RULE_20: Walking ones moves a single set bit, each row starting at value 1.
// RULE_21: Mono bars use bar width; even bars green value, odd bars blue value.
// RULE_22: Code 8 sends vertical colour bars down the pipeline.
// RULE_23: Output is a 12-bit pixel word on the parallel data port.
// RULE_24: User digital offset is signed -2048 to 2047, added after digital gain.
// RULE_25: Gain and offset results saturate to unsigned 12 bits.
// RULE_26: Pattern counters restart each row and each frame; the code restarts its row counters only each frame.
// RULE_27: Settings are sampled at frame start so a frame never mixes settings.
`default_nettype none
package pgbtp_pkg;
  localparam int PIX_W     = 12;
  localparam int CG_W      = 6;
  localparam int FG_W      = 7;
  localparam int AO_W      = 8;
  localparam int AG_W      = 7;
  localparam int OFS_W     = 13;
  localparam int ACC_W     = 20;
  localparam int FRAC_BITS = 3;
  localparam int COLOURS   = 4;
  localparam int BLC_LOG2  = 4;
  localparam int ROW_LOG2  = 3;
  localparam int EO_LOG2   = 3;
  localparam int CBAR_R    = 2;
  localparam int CBAR_G    = 1;
  localparam int CBAR_B    = 0;
  localparam logic [7:0]         GAIN_ONE  = 8'h08;
  localparam logic [PIX_W-1:0]   PIX_MAX   = 12'hfff;
  localparam logic [PIX_W-1:0]   PIX_ONE   = 12'h001;
  localparam logic [AO_W-1:0]    AOFF_MAX  = 8'hff;
  localparam logic [AO_W-1:0]    AOFF_STEP = 8'h01;
  localparam logic [ROW_LOG2:0]  ROW_LAST  = 4'h7;
  localparam logic [3:0] TP_FIELD = 4'h0;
  localparam logic [3:0] TP_HGRAD = 4'h1;
  localparam logic [3:0] TP_VGRAD = 4'h2;
  localparam logic [3:0] TP_DGRAD = 4'h3;
  localparam logic [3:0] TP_CLASS = 4'h4;
  localparam logic [3:0] TP_WALK  = 4'h5;
  localparam logic [3:0] TP_HBARS = 4'h6;
  localparam logic [3:0] TP_VBARS = 4'h7;
  localparam logic [3:0] TP_CBARS = 4'h8;

  typedef enum logic [1:0] {CLR_G1, CLR_RED, CLR_BLUE, CLR_G2} pgbtp_colour_e;

  typedef struct packed {
    logic [CG_W-1:0]         coarse_gain;
    logic                    gain_doubler;
    logic [FG_W-1:0]         fine_gain;
    logic [AO_W-1:0]         ana_offset;
    logic signed [PIX_W-1:0] user_offset;
    logic signed [PIX_W-1:0] eo_offset;
  } pgbtp_chan_cfg_s;

  typedef struct packed {
    logic             manual_black_level;
    logic             row_black_level_loop;
    logic             eo_manual;
    logic             lock_green;
    logic             lock_red_blue;
    logic             tp_enable;
    logic [3:0]       tp_mode;
    logic [PIX_W-1:0] black_target;
    logic [PIX_W-1:0] target_lo;
    logic [PIX_W-1:0] target_hi;
    logic [PIX_W-1:0] tp_green;
    logic [PIX_W-1:0] tp_red;
    logic [PIX_W-1:0] tp_blue;
    logic [PIX_W-1:0] tp_data;
    logic [PIX_W-1:0] bar_width;
  } pgbtp_glb_cfg_s;

  typedef struct packed {
    logic             valid;
    logic             dark_row;
    logic             dark_col;
    logic             col_odd;
    pgbtp_colour_e    colour;
    logic [PIX_W-1:0] data;
  } pgbtp_pix_s;
endpackage : pgbtp_pkg
`default_nettype wire

// ### rtl/pgbtp_pattern.sv
// Test pattern generator with column and row counters
`default_nettype none
module pgbtp_pattern (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      frame_start,
  input  wire logic                      row_start,
  input  wire logic                      pix_valid,
  input  wire logic                      pix_dark,
  input  wire logic                      col_odd,
  input  wire pgbtp_pkg::pgbtp_colour_e  colour,
  input  wire pgbtp_pkg::pgbtp_glb_cfg_s cfg,
  output logic [pgbtp_pkg::PIX_W-1:0]    pattern
);
  logic [pgbtp_pkg::PIX_W-1:0] hcnt_q, vcnt_q, walk_q, crun_q, rrun_q;
  logic [2:0]                  cidx_q, ridx_q;
  logic                        row_act_q;
  logic [pgbtp_pkg::PIX_W-1:0] wm1, clr_val, sel, cbar_val;
  logic [2:0]                  cbits;
  logic                        act, cbar_on;

  assign act = pix_valid && !pix_dark;
  assign wm1 = (cfg.bar_width == '0) ? '0 : cfg.bar_width - pgbtp_pkg::PIX_ONE;

  ////////////////////////////////////////
  // Column counters restart per row and frame; row counters (vcnt_q, rrun_q, ridx_q) restart per frame only
  always_ff @(posedge clk_sys) begin
    if (!nrst || frame_start) begin // RULE_26
      hcnt_q    <= '0;
      vcnt_q    <= '0;
      walk_q    <= pgbtp_pkg::PIX_ONE;
      crun_q    <= '0;
      rrun_q    <= '0;
      cidx_q    <= '0;
      ridx_q    <= '0;
      row_act_q <= 1'b0;
    end else if (row_start) begin // RULE_26
      hcnt_q    <= '0;
      walk_q    <= pgbtp_pkg::PIX_ONE; // RULE_20
      crun_q    <= '0;
      cidx_q    <= '0;
      row_act_q <= 1'b0;
      if (row_act_q) begin // RULE_19
        vcnt_q <= vcnt_q + pgbtp_pkg::PIX_ONE;
        rrun_q <= (rrun_q == wm1) ? '0 : rrun_q + pgbtp_pkg::PIX_ONE;
        ridx_q <= (rrun_q == wm1) ? ridx_q + 3'h1 : ridx_q;
      end
    end else if (act) begin
      hcnt_q    <= hcnt_q + pgbtp_pkg::PIX_ONE; // RULE_19
      walk_q    <= {walk_q[pgbtp_pkg::PIX_W-2:0], walk_q[pgbtp_pkg::PIX_W-1]}; // RULE_20
      row_act_q <= 1'b1;
      crun_q    <= (crun_q == wm1) ? '0 : crun_q + pgbtp_pkg::PIX_ONE; // RULE_21
      cidx_q    <= (crun_q == wm1) ? cidx_q + 3'h1 : cidx_q;
    end
  end

  ////////////////////////////////////////
  // Pattern selection
  assign clr_val = (colour == pgbtp_pkg::CLR_RED)  ? cfg.tp_red :
                   (colour == pgbtp_pkg::CLR_BLUE) ? cfg.tp_blue : cfg.tp_green; // RULE_18
  // White bar first, then colours in binary order down to black
  assign cbits    = ~cidx_q;
  assign cbar_on  = (colour == pgbtp_pkg::CLR_RED)  ? cbits[pgbtp_pkg::CBAR_R] :
                    (colour == pgbtp_pkg::CLR_BLUE) ? cbits[pgbtp_pkg::CBAR_B] :
                    cbits[pgbtp_pkg::CBAR_G];
  assign cbar_val = cbar_on ? pgbtp_pkg::PIX_MAX : '0; // RULE_22
  assign sel =
    (cfg.tp_mode == pgbtp_pkg::TP_HGRAD) ? hcnt_q : // RULE_19
    (cfg.tp_mode == pgbtp_pkg::TP_VGRAD) ? vcnt_q :
    (cfg.tp_mode == pgbtp_pkg::TP_DGRAD) ? hcnt_q + vcnt_q :
    (cfg.tp_mode == pgbtp_pkg::TP_CLASS) ? (col_odd ? ~cfg.tp_data : cfg.tp_data) : // RULE_17
    (cfg.tp_mode == pgbtp_pkg::TP_WALK)  ? walk_q :
    (cfg.tp_mode == pgbtp_pkg::TP_HBARS) ? (ridx_q[0] ? cfg.tp_blue : cfg.tp_green) : // RULE_21
    (cfg.tp_mode == pgbtp_pkg::TP_VBARS) ? (cidx_q[0] ? cfg.tp_blue : cfg.tp_green) :
    (cfg.tp_mode == pgbtp_pkg::TP_CBARS) ? cbar_val : clr_val;
  assign pattern = pix_dark ? clr_val : sel; // RULE_15
endmodule : pgbtp_pattern
`default_nettype wire

// ### rtl/pgbtp_pixel_path.sv
// Per-colour gain, offset, black level loops and test pattern pixel datapath
`default_nettype none
module pgbtp_pixel_path (
  input  wire logic                            CLK_SYS,
  input  wire logic                            NRST,
  input  wire logic                            FRAME_START,
  input  wire logic                            ROW_START,
  input  wire pgbtp_pkg::pgbtp_pix_s           PIX_IN,
  input  wire pgbtp_pkg::pgbtp_chan_cfg_s [3:0] CHAN_CFG,
  input  wire pgbtp_pkg::pgbtp_glb_cfg_s       GLB_CFG,
  output logic                                 PIX_OUT_VALID,
  output logic [pgbtp_pkg::PIX_W-1:0]          PIX_OUT_DATA,
  output logic [3:0][pgbtp_pkg::AG_W-1:0]      ANA_GAIN_X8,
  output logic [3:0][pgbtp_pkg::AO_W-1:0]      ANA_OFFSET,
  output logic [3:0][pgbtp_pkg::OFS_W-1:0]     ROW_OFFSET,
  output logic [3:0][pgbtp_pkg::OFS_W-1:0]     EO_OFFSET
);
  localparam int PW = pgbtp_pkg::PIX_W;
  localparam int AW = pgbtp_pkg::ACC_W;
  localparam int OW = pgbtp_pkg::OFS_W;
  localparam int NC = pgbtp_pkg::COLOURS;
  localparam int BL = pgbtp_pkg::BLC_LOG2;
  localparam int RL = pgbtp_pkg::ROW_LOG2;
  localparam int EL = pgbtp_pkg::EO_LOG2;

  ////////////////////////////////////////
  // Helper functions
  function automatic logic [pgbtp_pkg::AG_W-1:0] ana_gain_x8(
    input logic [pgbtp_pkg::CG_W-1:0] cg,
    input logic                       dbl);
    ana_gain_x8 = dbl ? {cg, 1'b0} : {1'b0, cg};
  endfunction : ana_gain_x8

  function automatic logic [AW-1:0] mul_q3(
    input logic [PW-1:0] a,
    input logic [7:0]    b);
    logic [AW-1:0] p;
    p = AW'(a) * AW'(b);
    mul_q3 = p >> pgbtp_pkg::FRAC_BITS;
  endfunction : mul_q3

  function automatic logic [PW-1:0] sat12(input logic signed [AW-1:0] v);
    if (v < 0)
      sat12 = '0;
    else if (v > $signed(AW'(pgbtp_pkg::PIX_MAX)))
      sat12 = pgbtp_pkg::PIX_MAX;
    else
      sat12 = v[PW-1:0];
  endfunction : sat12

  function automatic logic signed [OW-1:0] diff13(
    input logic [PW-1:0] a,
    input logic [PW-1:0] b);
    diff13 = $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction : diff13

  function automatic logic [pgbtp_pkg::AO_W-1:0] blc_step(
    input logic [pgbtp_pkg::AO_W-1:0] off,
    input logic [PW-1:0]              avg,
    input logic [PW-1:0]              lo,
    input logic [PW-1:0]              hi);
    blc_step = off;
    if (avg < lo && off != pgbtp_pkg::AOFF_MAX)
      blc_step = off + pgbtp_pkg::AOFF_STEP;
    else if (avg > hi && off != '0)
      blc_step = off - pgbtp_pkg::AOFF_STEP;
  endfunction : blc_step

  ////////////////////////////////////////
  // Settings sampled at frame start
  pgbtp_pkg::pgbtp_glb_cfg_s        glb_q;
  pgbtp_pkg::pgbtp_chan_cfg_s [3:0] chan_q;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      glb_q  <= '0;
      chan_q <= '0;
    end else if (FRAME_START) begin // RULE_27
      glb_q  <= GLB_CFG;
      chan_q <= CHAN_CFG;
    end
  end

  ////////////////////////////////////////
  // Stage 0: pattern injection at the pipe head
  logic [PW-1:0]         pat_val;
  pgbtp_pkg::pgbtp_pix_s s0_d, s0_q;

  pgbtp_pattern u_pattern (
    .clk_sys     (CLK_SYS),
    .nrst        (NRST),
    .frame_start (FRAME_START),
    .row_start   (ROW_START),
    .pix_valid   (PIX_IN.valid),
    .pix_dark    (PIX_IN.dark_row || PIX_IN.dark_col),
    .col_odd     (PIX_IN.col_odd),
    .colour      (PIX_IN.colour),
    .cfg         (glb_q),
    .pattern     (pat_val)
  );

  always_comb begin
    s0_d = PIX_IN;
    if (glb_q.tp_enable)
      s0_d.data = pat_val; // RULE_14
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST)
      s0_q <= '0;
    else
      s0_q <= s0_d;
  end

  ////////////////////////////////////////
  // Analog black level loop
  logic [PW+BL-1:0]            bsum_q [NC];
  logic [BL:0]                 bcnt_q [NC];
  logic [pgbtp_pkg::AO_W-1:0]  aoff_q [NC];
  logic                        blc_take;

  assign blc_take = s0_q.valid && s0_q.dark_row && !glb_q.manual_black_level;

  always_ff @(posedge CLK_SYS) begin
    for (int c = 0; c < NC; c++) begin
      if (!NRST) begin
        bsum_q[c] <= '0;
        bcnt_q[c] <= '0;
        aoff_q[c] <= '0;
      end else if (glb_q.manual_black_level) begin
        aoff_q[c] <= chan_q[c].ana_offset; // RULE_11
        bsum_q[c] <= '0; // RULE_12
        bcnt_q[c] <= '0;
      end else if (FRAME_START) begin
        bsum_q[c] <= '0;
        bcnt_q[c] <= '0;
        if (bcnt_q[c][BL])
          aoff_q[c] <= blc_step(aoff_q[c], bsum_q[c][PW+BL-1:BL],
                                glb_q.target_lo, glb_q.target_hi); // RULE_08 RULE_05
      end else if (blc_take && s0_q.colour == 2'(c) && !bcnt_q[c][BL]) begin
        bsum_q[c] <= bsum_q[c] + (PW+BL)'(s0_q.data);
        bcnt_q[c] <= bcnt_q[c] + 1'b1;
      end
    end
  end

  logic lock_g, lock_rb;

  assign lock_g  = glb_q.lock_green &&
                   chan_q[pgbtp_pkg::CLR_G1].coarse_gain == chan_q[pgbtp_pkg::CLR_G2].coarse_gain &&
                   chan_q[pgbtp_pkg::CLR_G1].gain_doubler == chan_q[pgbtp_pkg::CLR_G2].gain_doubler;
  assign lock_rb = glb_q.lock_red_blue &&
                   chan_q[pgbtp_pkg::CLR_RED].coarse_gain == chan_q[pgbtp_pkg::CLR_BLUE].coarse_gain &&
                   chan_q[pgbtp_pkg::CLR_RED].gain_doubler == chan_q[pgbtp_pkg::CLR_BLUE].gain_doubler;

  assign ANA_OFFSET[pgbtp_pkg::CLR_G1]   = aoff_q[pgbtp_pkg::CLR_G1];
  assign ANA_OFFSET[pgbtp_pkg::CLR_RED]  = aoff_q[pgbtp_pkg::CLR_RED];
  assign ANA_OFFSET[pgbtp_pkg::CLR_BLUE] = lock_rb ? aoff_q[pgbtp_pkg::CLR_RED] :
                                           aoff_q[pgbtp_pkg::CLR_BLUE]; // RULE_10
  assign ANA_OFFSET[pgbtp_pkg::CLR_G2]   = lock_g ? aoff_q[pgbtp_pkg::CLR_G1] :
                                           aoff_q[pgbtp_pkg::CLR_G2]; // RULE_09

  ////////////////////////////////////////
  // Row-wise digital offset from dark columns
  logic [PW+RL-1:0]       rsum_q [NC];
  logic [RL:0]            rcnt_q [NC];
  logic signed [OW-1:0]   roff_q [NC];
  logic [PW+RL-1:0]       rsum_nx;
  logic                   row_take;

  assign row_take = s0_q.valid && s0_q.dark_col && glb_q.row_black_level_loop;
  assign rsum_nx  = rsum_q[s0_q.colour] + (PW+RL)'(s0_q.data);

  always_ff @(posedge CLK_SYS) begin
    for (int c = 0; c < NC; c++) begin
      if (!NRST) begin
        rsum_q[c] <= '0;
        rcnt_q[c] <= '0;
        roff_q[c] <= '0;
      end else begin
        if (!glb_q.row_black_level_loop)
          roff_q[c] <= OW'(chan_q[c].user_offset); // RULE_06 RULE_24
        if (ROW_START) begin
          rsum_q[c] <= '0;
          rcnt_q[c] <= '0;
        end else if (row_take && s0_q.colour == 2'(c) && !rcnt_q[c][RL]) begin
          rsum_q[c] <= rsum_nx;
          rcnt_q[c] <= rcnt_q[c] + 1'b1;
          if (rcnt_q[c] == pgbtp_pkg::ROW_LAST)
            roff_q[c] <= diff13(glb_q.black_target, rsum_nx[PW+RL-1:RL]); // RULE_06
        end
      end
    end
  end

  ////////////////////////////////////////
  // Even/odd column offset from dark rows
  logic [PW+EL-1:0]       esum_q [NC][2];
  logic [EL:0]            ecnt_q [NC][2];
  logic signed [OW-1:0]   eoff_q [NC];
  logic                   eo_take;

  assign eo_take = s0_q.valid && s0_q.dark_row && !glb_q.eo_manual;

  always_ff @(posedge CLK_SYS) begin
    for (int c = 0; c < NC; c++) begin
      if (!NRST) begin
        eoff_q[c] <= '0;
        for (int p = 0; p < 2; p++) begin
          esum_q[c][p] <= '0;
          ecnt_q[c][p] <= '0;
        end
      end else if (glb_q.eo_manual) begin
        eoff_q[c] <= OW'(chan_q[c].eo_offset); // RULE_07
      end else if (FRAME_START) begin
        if (ecnt_q[c][0][EL] && ecnt_q[c][1][EL])
          eoff_q[c] <= diff13(esum_q[c][0][PW+EL-1:EL], esum_q[c][1][PW+EL-1:EL]); // RULE_07
        for (int p = 0; p < 2; p++) begin
          esum_q[c][p] <= '0;
          ecnt_q[c][p] <= '0;
        end
      end else if (eo_take && s0_q.colour == 2'(c) && !ecnt_q[c][s0_q.col_odd][EL]) begin
        esum_q[c][s0_q.col_odd] <= esum_q[c][s0_q.col_odd] + (PW+EL)'(s0_q.data);
        ecnt_q[c][s0_q.col_odd] <= ecnt_q[c][s0_q.col_odd] + 1'b1;
      end
    end
  end

  for (genvar g = 0; g < NC; g++) begin : g_chan
    assign ANA_GAIN_X8[g] = ana_gain_x8(chan_q[g].coarse_gain, chan_q[g].gain_doubler); // RULE_01 RULE_02
    assign ROW_OFFSET[g]  = roff_q[g];
    assign EO_OFFSET[g]   = eoff_q[g];
  end

  ////////////////////////////////////////
  // Stage 1: digital gain
  pgbtp_pkg::pgbtp_pix_s s1_d, s1_q;
  logic [7:0]            dg_mul;

  assign dg_mul = pgbtp_pkg::GAIN_ONE + 8'(chan_q[s0_q.colour].fine_gain);

  always_comb begin
    s1_d      = s0_q;
    s1_d.data = sat12($signed(mul_q3(s0_q.data, dg_mul))); // RULE_04 RULE_25
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST)
      s1_q <= '0;
    else
      s1_q <= s1_d;
  end

  ////////////////////////////////////////
  // Stage 2: offsets and final black correction
  logic [AW-1:0]        corr;
  logic signed [AW-1:0] sum2;
  logic [PW-1:0]        out_q;
  logic                 out_valid_q;

  // Black shift that the fine gain adds to the target level
  assign corr = s1_q.dark_col ? '0 :
                mul_q3(glb_q.black_target, 8'(chan_q[s1_q.colour].fine_gain)); // RULE_13
  assign sum2 = $signed(AW'(s1_q.data)) + AW'(roff_q[s1_q.colour]) // RULE_24
              + (s1_q.col_odd ? AW'(eoff_q[s1_q.colour]) : '0)
              - $signed(corr);

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      out_q       <= '0;
      out_valid_q <= 1'b0;
    end else begin
      out_q       <= sat12(sum2); // RULE_25 RULE_13
      out_valid_q <= s1_q.valid;
    end
  end

  assign PIX_OUT_VALID = out_valid_q;
  assign PIX_OUT_DATA  = out_q; // RULE_23

  ////////////////////////////////////////
  // Checks
  sequence s_field_red;
    !FRAME_START && glb_q.tp_enable && glb_q.tp_mode == pgbtp_pkg::TP_FIELD &&
    PIX_IN.valid && PIX_IN.colour == pgbtp_pkg::CLR_RED;
  endsequence

  sequence s_dark_green;
    !FRAME_START && glb_q.tp_enable && PIX_IN.valid && PIX_IN.dark_row &&
    PIX_IN.colour == pgbtp_pkg::CLR_G1;
  endsequence

  cfg_hold_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_27
    !FRAME_START |=> $stable(glb_q) && $stable(chan_q))
    else $error("Settings changed outside frame start");

  gain_form_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_01
    ANA_GAIN_X8[1] == 7'(chan_q[1].coarse_gain) * (chan_q[1].gain_doubler ? 7'h2 : 7'h1))
    else $error("Analog gain does not match coarse gain and doubler");

  manual_load_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_12
    glb_q.manual_black_level && !FRAME_START ##1 glb_q.manual_black_level
    |-> aoff_q[0] == $past(chan_q[0].ana_offset) && bcnt_q[0] == '0)
    else $error("Manual mode offset not in use or sampling active");

  green_lock_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_09
    glb_q.lock_green && chan_q[0].coarse_gain == chan_q[3].coarse_gain &&
    chan_q[0].gain_doubler == chan_q[3].gain_doubler |-> ANA_OFFSET[3] == ANA_OFFSET[0])
    else $error("Green lock not applied");

  rb_lock_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_10
    glb_q.lock_red_blue && chan_q[1].coarse_gain == chan_q[2].coarse_gain &&
    chan_q[1].gain_doubler == chan_q[2].gain_doubler |-> ANA_OFFSET[2] == ANA_OFFSET[1])
    else $error("Red/blue lock not applied");

  blc_step_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_08
    !glb_q.manual_black_level && !$past(glb_q.manual_black_level)
    |-> (8'(aoff_q[1] - $past(aoff_q[1]))) inside {8'h00, 8'h01, 8'hff})
    else $error("Analog offset moved by more than one step");

  blc_idle_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_08
    !glb_q.manual_black_level && !FRAME_START |=> $stable(aoff_q[1]))
    else $error("Analog offset moved between frames");

  pipe_lat_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_23
    PIX_IN.valid |-> ##3 PIX_OUT_VALID)
    else $error("Pixel lost in pipeline");

  row_user_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_06
    !glb_q.row_black_level_loop && !FRAME_START |=> roff_q[2] == OW'($past(chan_q[2].user_offset)))
    else $error("Row offset does not follow user offset");

  field_val_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_18
    s_field_red |=> s0_q.data == $past(glb_q.tp_red))
    else $error("Colour field red value not injected");

  dark_tp_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_15
    s_dark_green |=> s0_q.data == $past(glb_q.tp_green))
    else $error("Dark pixel did not take green pattern value");

  sat_out_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RULE_25
    sum2 < 0 |=> PIX_OUT_DATA == '0)
    else $error("Negative result not clamped to zero");
endmodule : pgbtp_pixel_path
`default_nettype wire

// ### bench/pgbtp_capture.sv
// Capture model that takes each finished pixel from the datapath
`default_nettype none
module pgbtp_capture (
  input  wire logic        clk,
  input  wire logic        valid,
  input  wire logic [11:0] data,
  output logic             got,
  output logic [11:0]      pix
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) begin
    got <= valid;
    pix <= data;
  end
endmodule : pgbtp_capture
`default_nettype wire

// ### bench/test_pgbtp_pixel_path.sv
// Self-checking bench for the pixel gain, black level and pattern path
`default_nettype none
module test_pgbtp_pixel_path;
  timeunit 1ns;
  timeprecision 1ns;
  logic                             clk_sys = 1'b0;
  logic                             nrst = 1'b0;
  logic                             frame_start = 1'b0;
  logic                             row_start = 1'b0;
  pgbtp_pkg::pgbtp_pix_s            pix_in = '0;
  pgbtp_pkg::pgbtp_chan_cfg_s [3:0] chan_cfg = '0;
  pgbtp_pkg::pgbtp_glb_cfg_s        glb_cfg = '0;
  logic                             out_valid, got;
  logic [11:0]                      out_data, pix;
  logic [3:0][6:0]                  ana_gain;
  logic [3:0][7:0]                  ana_off;
  logic [3:0][12:0]                 row_off, eo_off;
  logic [11:0]                      expq[$];
  int                               num_errors = 0;
  int                               comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  pgbtp_pixel_path dut (.CLK_SYS(clk_sys), .NRST(nrst), .FRAME_START(frame_start),
    .ROW_START(row_start), .PIX_IN(pix_in), .CHAN_CFG(chan_cfg), .GLB_CFG(glb_cfg),
    .PIX_OUT_VALID(out_valid), .PIX_OUT_DATA(out_data), .ANA_GAIN_X8(ana_gain),
    .ANA_OFFSET(ana_off), .ROW_OFFSET(row_off), .EO_OFFSET(eo_off));
  pgbtp_capture cap (.clk(clk_sys), .valid(out_valid), .data(out_data), .got(got), .pix(pix));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (e !== g) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [11:0] sat(input int v);
    sat = (v < 0) ? 12'h000 : (v > 4095) ? 12'hfff : v[11:0];
  endfunction : sat
  function automatic logic [11:0] cval(input logic [1:0] c);
    cval = (c == 2'h1) ? glb_cfg.tp_red : (c == 2'h2) ? glb_cfg.tp_blue : glb_cfg.tp_green;
  endfunction : cval
  // Frame or row pulse, always in a cycle without a pixel
  task automatic pulse(input logic row);
    @(posedge clk_sys);
    pix_in.valid <= 1'b0;
    row_start    <= row;
    frame_start  <= !row;
    @(posedge clk_sys);
    row_start    <= 1'b0;
    frame_start  <= 1'b0;
  endtask : pulse
  task automatic send(input logic [1:0] c, input logic odd, dc, input logic [11:0] d, e);
    @(posedge clk_sys);
    pix_in <= '{1'b1, 1'b0, dc, odd, pgbtp_pkg::pgbtp_colour_e'(c), d};
    expq.push_back(e);
  endtask : send
  always @(negedge clk_sys) begin
    if (got === 1'b1) begin
      if (expq.size() == 0) chk("extra pixel", 16'h0, 16'h1);
      else chk("pixel", {4'h0, expq.pop_front()}, {4'h0, pix});
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int fg, uo, eo, bt, d, cg, db;
    logic [11:0] e, td;
    logic [1:0] c;
    logic odd, dc, lk;
    logic [6:0] gx;
    logic [7:0] a0;
    void'($urandom(32'h33ed));
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk("valid after reset", 16'h0, {15'h0, out_valid});
    gx = 7'h00;
    for (int f = 0; f < 6; f++) begin
      @(posedge clk_sys);
      pix_in.valid <= 1'b0;
      fg = $urandom_range(127);
      uo = $urandom_range(4095) - 2048;
      eo = $urandom_range(255) - 128;
      bt = $urandom_range(255);
      cg = $urandom_range(32, 8);
      db = $urandom_range(1);
      a0 = 8'($urandom);
      lk = 1'($urandom);
      for (int k = 0; k < 4; k++)
        chan_cfg[k] <= '{cg[5:0], db[0], fg[6:0], (k == 0) ? a0 : ~a0, uo[11:0], eo[11:0]};
      glb_cfg <= '{manual_black_level: 1'b1, eo_manual: 1'b1, lock_green: lk,
                   black_target: bt[11:0], default: '0};
      @(negedge clk_sys);
      chk("gain before frame", {9'h0, gx}, {9'h0, ana_gain[0]});
      pulse(1'b0);
      @(negedge clk_sys);
      gx = 7'(cg << db);
      chk("analog gain", {9'h0, gx}, {9'h0, ana_gain[3]});
      pulse(1'b1);
      @(negedge clk_sys);
      chk("green offset", {8'h0, lk ? a0 : ~a0}, {8'h0, ana_off[3]});
      chk("row offset", {3'h0, 13'(uo)}, {3'h0, row_off[1]});
      chk("even odd offset", {3'h0, 13'(eo)}, {3'h0, eo_off[2]});
      for (int i = 0; i < 4; i++) begin
        c = 2'($urandom);
        odd = 1'($urandom);
        dc = 1'($urandom);
        d = $urandom_range(4095);
        e = sat(int'(sat((d * (8 + fg)) >> 3)) + uo + (odd ? eo : 0) - (dc ? 0 : (bt * fg) >> 3));
        send(c, odd, dc, d[11:0], e);
      end
    end
    for (int j = 0; j < 5; j++) begin
      @(posedge clk_sys);
      pix_in.valid <= 1'b0;
      td = 12'($urandom);
      chan_cfg <= '0;
      glb_cfg <= '{manual_black_level: 1'b1, eo_manual: 1'b1, tp_enable: 1'b1,
                   tp_mode: 4'((j == 0) ? 0 : (j == 3) ? 1 : (j == 4) ? 7 : j + 3),
                   tp_green: 12'($urandom),
                   tp_red: 12'($urandom), tp_blue: 12'($urandom), tp_data: td, default: '0};
      pulse(1'b0);
      pulse(1'b1);
      c = 2'($urandom);
      send(c, 1'b0, 1'b1, 12'($urandom), cval(c));
      for (int i = 0; i < 2; i++) begin
        c = 2'($urandom);
        e = (j == 0) ? cval(c) : (j == 1) ? (i ? ~td : td) : (j == 2) ? 12'(i + 1) :
            (j == 3) ? 12'(i) : (i ? glb_cfg.tp_blue : glb_cfg.tp_green);
        send(c, i[0], 1'b0, 12'($urandom), e);
      end
    end
    pulse(1'b1);
    repeat (6) @(posedge clk_sys);
    chk("pixels left", 16'h0, 16'(expq.size()));
    stop_test();
  end
  initial begin
    #100us;
    num_errors++;
    stop_test();
  end
endmodule : test_pgbtp_pixel_path
`default_nettype wire
